// [design/pcie_msi_vpd_capability_regs.sv]
// Upper MSI capability, product data capability with its EEPROM access
// engine, vendor capability header and two test registers, on APB.
// Assumes an APB master on i_clock and an EEPROM controller that answers
// each held request with a one-cycle done pulse.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module pcie_msi_vpd_capability_regs (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_upstream_port,
  input wire logic i_msi_send,
  output logic o_msi_valid,
  output logic o_msi_addr_64,
  output logic [31:0] o_msi_upper_address,
  output logic [15:0] o_msi_payload,
  output logic o_ee_req,
  output pcie_cap_pkg::ee_cmd_t o_ee_cmd,
  input wire logic i_ee_done,
  input wire logic [31:0] i_ee_rdata,
  output logic o_irq
);

  // Register state.
  logic [31:0] msi_upper_ff;
  logic [15:0] msi_payload_ff;
  logic msi_64bit_capable_ff;
  logic [5:0] pd_addr_ff;
  logic op_flag_ff;
  logic busy_ff;
  logic [31:0] pd_word_ff;
  logic [31:0] test_first_ff;
  logic [31:0] test_second_ff;

  // Bus decode.
  logic access;
  logic wr_fire;
  logic rd_hit;
  logic [31:0] rd_data;
  logic [31:0] msi_upper_rd;
  logic [31:0] msi_data_rd;
  logic [31:0] pd_cap_rd;
  logic [31:0] vnd_cap_rd;

  // Engine and interrupt wiring.
  logic start;
  pcie_cap_pkg::ee_cmd_t cmd;
  logic eng_done;
  logic [31:0] eng_rdata;
  logic [pcie_cap_pkg::IRQ_W-1:0] irq_set;
  logic [pcie_cap_pkg::IRQ_W-1:0] irq_status;
  logic [pcie_cap_pkg::IRQ_W-1:0] irq_mask;
  logic irq_clr_wr;
  logic irq_mask_wr;

  // Merges write data into a register one byte lane at a time.
  // Lanes whose strobe is clear keep their old contents.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Every access gets one wait state, so pready comes from a flop and the
  // read data are settled before the master samples them.
  assign access = i_psel && i_penable;
  assign wr_fire = access && o_pready && i_pwrite;

  // Register images as software sees them.
  // Reserved bits of each dword read as zero.
  assign msi_upper_rd = msi_upper_ff;
  assign msi_data_rd = {16'h0000, msi_payload_ff};
  assign pd_cap_rd = {op_flag_ff, 7'h00, pd_addr_ff, 2'h0,
                      pcie_cap_pkg::PD_NEXT_PTR,
                      pcie_cap_pkg::PD_CAP_ID};
  assign vnd_cap_rd = {pcie_cap_pkg::VND_LENGTH,
                       pcie_cap_pkg::VND_NEXT_PTR,
                       pcie_cap_pkg::VND_CAP_ID};

  // Read mux; MSI registers exist only on a downstream port and the
  // product data registers only on the upstream port.
  // A hidden or unmapped offset reads zero and answers with an error, so
  // software probing from the wrong role sees a clear fault.
  always_comb begin
    rd_hit = 1'b1;
    rd_data = 32'h0000_0000;
    case (i_paddr)
      pcie_cap_pkg::OFS_MSI_UPPER: begin
        rd_hit = !i_upstream_port;
        rd_data = msi_upper_rd;
      end
      pcie_cap_pkg::OFS_MSI_DATA: begin
        rd_hit = !i_upstream_port;
        rd_data = msi_data_rd;
      end
      pcie_cap_pkg::OFS_PD_CAP: begin
        rd_hit = i_upstream_port;
        rd_data = pd_cap_rd;
      end
      pcie_cap_pkg::OFS_PD_WORD: begin
        rd_hit = i_upstream_port;
        rd_data = pd_word_ff;
      end
      pcie_cap_pkg::OFS_VND_CAP: begin
        rd_data = vnd_cap_rd;
      end
      pcie_cap_pkg::OFS_TEST_FIRST: begin
        rd_data = test_first_ff;
      end
      pcie_cap_pkg::OFS_TEST_SECOND: begin
        rd_data = test_second_ff;
      end
      pcie_cap_pkg::OFS_IRQ_STATUS: begin
        rd_data = {30'h0000_0000, irq_status};
      end
      pcie_cap_pkg::OFS_IRQ_MASK: begin
        rd_data = {30'h0000_0000, irq_mask};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
    if (!rd_hit) begin
      rd_data = 32'h0000_0000;
    end
  end

  // APB handshake: pready rises in the second access cycle and falls
  // again right after, which also keeps back-to-back transfers apart.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= access && !o_pready;
      o_pslverr <= access && !o_pready && !rd_hit;
      if (access && !o_pready && !i_pwrite) begin
        o_prdata <= rd_data;
      end else begin
        o_prdata <= 32'h0000_0000;
      end
    end
  end

  // MSI capability registers.
  // Writes land only on the edge at which pready is seen, so a stalled
  // master never commits half a transfer.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      msi_upper_ff <= pcie_cap_pkg::MSI_UPPER_RST;
      msi_payload_ff <= pcie_cap_pkg::MSI_PAYLOAD_RST;
    end else if (wr_fire && !i_upstream_port) begin
      if (i_paddr == pcie_cap_pkg::OFS_MSI_UPPER) begin
        msi_upper_ff <= merge(msi_upper_ff, i_pwdata, i_pstrb);
      end
      // Only byte lanes 0 and 1 carry the payload; lanes 2 and 3 are
      // reserved in this dword and a write to them is dropped.
      if (i_paddr == pcie_cap_pkg::OFS_MSI_DATA && i_pstrb[0]) begin
        msi_payload_ff[7:0] <= i_pwdata[7:0];
      end
      if (i_paddr == pcie_cap_pkg::OFS_MSI_DATA && i_pstrb[1]) begin
        msi_payload_ff[15:8] <= i_pwdata[15:8];
      end
    end
  end

  // The capability bit is fixed; it is held in a flop so the output and
  // the address selection below share one source.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      msi_64bit_capable_ff <= pcie_cap_pkg::MSI_64BIT_CAPABLE_RST;
    end else begin
      msi_64bit_capable_ff <= pcie_cap_pkg::MSI_64BIT_CAPABLE_RST;
    end
  end

  // MSI message presentation: one valid cycle per send request, with the
  // upper address zeroed when only 32-bit addressing is advertised.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_msi_valid <= 1'b0;
      o_msi_addr_64 <= 1'b0;
      o_msi_upper_address <= 32'h0000_0000;
      o_msi_payload <= 16'h0000;
    end else begin
      o_msi_valid <= i_msi_send && !i_upstream_port;
      o_msi_addr_64 <= msi_64bit_capable_ff;
      if (i_msi_send && !i_upstream_port) begin
        o_msi_upper_address <= msi_64bit_capable_ff ?
                               msi_upper_ff : 32'h0000_0000;
        o_msi_payload <= msi_payload_ff;
      end
    end
  end

  // A write to the flag byte while idle launches an access; writes to the
  // address, flag and data while busy are dropped so a polled access is
  // never disturbed midway.
  assign start = wr_fire && i_upstream_port && !busy_ff &&
                 (i_paddr == pcie_cap_pkg::OFS_PD_CAP) && i_pstrb[3];
  assign cmd.write = i_pwdata[pcie_cap_pkg::PD_FLAG_BIT];
  assign cmd.addr = i_pstrb[2] ?
                    i_pwdata[pcie_cap_pkg::PD_ADDR_LSB +:
                             pcie_cap_pkg::PD_ADDR_W] : pd_addr_ff;
  assign cmd.data = pd_word_ff;

  // Dword address field.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pd_addr_ff <= pcie_cap_pkg::PD_ADDR_RST;
    end else if (wr_fire && i_upstream_port && !busy_ff &&
                 i_paddr == pcie_cap_pkg::OFS_PD_CAP && i_pstrb[2]) begin
      pd_addr_ff <= i_pwdata[pcie_cap_pkg::PD_ADDR_LSB +:
                             pcie_cap_pkg::PD_ADDR_W];
    end
  end

  // Operation flag: takes the written direction at start and flips when
  // the EEPROM cycle ends, which is what software polls for.
  // An access cannot be aborted: a slow EEPROM only stretches the poll.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      op_flag_ff <= pcie_cap_pkg::PD_FLAG_RST;
      busy_ff <= 1'b0;
    end else if (start) begin
      op_flag_ff <= cmd.write;
      busy_ff <= 1'b1;
    end else if (eng_done && busy_ff) begin
      op_flag_ff <= !op_flag_ff;
      busy_ff <= 1'b0;
    end
  end

  // Data word: software writes supply the next table write; a finished
  // table read replaces it. One register serves both, so a read access
  // overwrites data staged for a later write.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pd_word_ff <= pcie_cap_pkg::PD_WORD_RST;
    end else if (eng_done && busy_ff && !op_flag_ff) begin
      pd_word_ff <= eng_rdata;
    end else if (wr_fire && i_upstream_port && !busy_ff &&
                 i_paddr == pcie_cap_pkg::OFS_PD_WORD) begin
      pd_word_ff <= merge(pd_word_ff, i_pwdata, i_pstrb);
    end
  end

  // Test registers: plain storage with no effect on this block.
  // Only software ever sees their reset values.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      test_first_ff <= pcie_cap_pkg::TEST_FIRST_RST;
      test_second_ff <= pcie_cap_pkg::TEST_SECOND_RST;
    end else if (wr_fire) begin
      if (i_paddr == pcie_cap_pkg::OFS_TEST_FIRST) begin
        test_first_ff <= merge(test_first_ff, i_pwdata, i_pstrb);
      end
      if (i_paddr == pcie_cap_pkg::OFS_TEST_SECOND) begin
        test_second_ff <= merge(test_second_ff, i_pwdata, i_pstrb);
      end
    end
  end

  // The engine owns the EEPROM handshake; this block only tracks busy
  // and the flag, so the two never disagree on when an access ended.
  ee_access_engine u_engine (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_start(start),
    .i_cmd(cmd),
    .i_ee_done(i_ee_done),
    .i_ee_rdata(i_ee_rdata),
    .o_ee_req(o_ee_req),
    .o_ee_cmd(o_ee_cmd),
    .o_done(eng_done),
    .o_rdata(eng_rdata)
  );

  // Completion events for the interrupt status.
  always_comb begin
    irq_set = '0;
    irq_set[pcie_cap_pkg::IRQ_RD_DONE] = eng_done && busy_ff && !op_flag_ff;
    irq_set[pcie_cap_pkg::IRQ_WR_DONE] = eng_done && busy_ff && op_flag_ff;
  end

  // Status clear and mask writes use lane 0 only; the upper lanes are
  // reserved and a write to them changes nothing.
  assign irq_clr_wr = wr_fire && i_paddr == pcie_cap_pkg::OFS_IRQ_STATUS &&
                      i_pstrb[0];
  assign irq_mask_wr = wr_fire && i_paddr == pcie_cap_pkg::OFS_IRQ_MASK &&
                       i_pstrb[0];

  // Event status, mask and the level interrupt; a completion and its
  // clear in one cycle leave the bit set, so no event is lost.
  sticky_irq #(
    .W(pcie_cap_pkg::IRQ_W)
  ) u_irq (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_set(irq_set),
    .i_clr_wr(irq_clr_wr),
    .i_clr_bits(i_pwdata[pcie_cap_pkg::IRQ_W-1:0]),
    .i_mask_wr(irq_mask_wr),
    .i_mask_bits(i_pwdata[pcie_cap_pkg::IRQ_W-1:0]),
    .o_status(irq_status),
    .o_mask(irq_mask),
    .o_irq(o_irq)
  );

endmodule // pcie_msi_vpd_capability_regs

// [design/pcie_cap_pkg.sv]
// Constants, field layouts and carrier types for the capability registers.
// Assumes a 32-bit APB register bus with byte addresses in paddr[7:0].
package pcie_cap_pkg;

  // Byte offsets of the registers in configuration space.
  localparam logic [7:0] OFS_MSI_UPPER = 8'h94;
  localparam logic [7:0] OFS_MSI_DATA = 8'h98;
  localparam logic [7:0] OFS_PD_CAP = 8'h9c;
  localparam logic [7:0] OFS_PD_WORD = 8'ha0;
  localparam logic [7:0] OFS_VND_CAP = 8'ha4;
  localparam logic [7:0] OFS_TEST_FIRST = 8'ha8;
  localparam logic [7:0] OFS_TEST_SECOND = 8'hac;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'he0;
  localparam logic [7:0] OFS_IRQ_MASK = 8'he4;

  // Field positions and widths.
  localparam int unsigned PD_ADDR_LSB = 18;
  localparam int unsigned PD_ADDR_W = 6;
  localparam int unsigned PD_FLAG_BIT = 31;
  localparam int unsigned MSI_PAYLOAD_W = 16;
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_RD_DONE = 0;
  localparam int unsigned IRQ_WR_DONE = 1;

  // Reset and fixed values.
  localparam logic [31:0] MSI_UPPER_RST = 32'h0000_0000;
  localparam logic [15:0] MSI_PAYLOAD_RST = 16'h0000;
  localparam logic MSI_64BIT_CAPABLE_RST = 1'b1;
  localparam logic [7:0] PD_CAP_ID = 8'h03;
  localparam logic [7:0] PD_NEXT_PTR = 8'ha4;
  localparam logic [5:0] PD_ADDR_RST = 6'h00;
  localparam logic PD_FLAG_RST = 1'b0;
  localparam logic [31:0] PD_WORD_RST = 32'h0000_0000;
  localparam logic [7:0] VND_CAP_ID = 8'h09;
  localparam logic [7:0] VND_NEXT_PTR = 8'hc4;
  localparam logic [15:0] VND_LENGTH = 16'h000c;
  localparam logic [31:0] TEST_FIRST_RST = 32'h0400_1060;
  localparam logic [31:0] TEST_SECOND_RST = 32'h0400_0800;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  // One access to the product data table in EEPROM.
  typedef struct packed {
    logic write;
    logic [5:0] addr;
    logic [31:0] data;
  } ee_cmd_t;

  // Access engine states.
  typedef enum logic {
    ENG_IDLE,
    ENG_WAIT
  } eng_state_t;

endpackage

// [design/ee_access_engine.sv]
// Sequencer for one dword access to the EEPROM-resident product table.
// Assumes the EEPROM controller answers a held request with a done pulse.
`timescale 1ns/1ps
module ee_access_engine (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_start,
  input pcie_cap_pkg::ee_cmd_t i_cmd,
  input wire logic i_ee_done,
  input wire logic [31:0] i_ee_rdata,
  output logic o_ee_req,
  output pcie_cap_pkg::ee_cmd_t o_ee_cmd,
  output logic o_done,
  output logic [31:0] o_rdata
);

  pcie_cap_pkg::eng_state_t state_ff;

  // The request stays up until the controller reports the cycle finished,
  // so a slow EEPROM simply stretches the wait.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= pcie_cap_pkg::ENG_IDLE;
      o_ee_req <= 1'b0;
      o_ee_cmd <= '0;
      o_done <= 1'b0;
      o_rdata <= 32'h0000_0000;
    end else begin
      o_done <= 1'b0;
      case (state_ff)
        pcie_cap_pkg::ENG_IDLE: begin
          if (i_start) begin
            o_ee_req <= 1'b1;
            o_ee_cmd <= i_cmd;
            state_ff <= pcie_cap_pkg::ENG_WAIT;
          end
        end
        pcie_cap_pkg::ENG_WAIT: begin
          if (i_ee_done) begin
            o_ee_req <= 1'b0;
            o_done <= 1'b1;
            if (!o_ee_cmd.write) begin
              o_rdata <= i_ee_rdata;
            end
            state_ff <= pcie_cap_pkg::ENG_IDLE;
          end
        end
        default: begin
          state_ff <= pcie_cap_pkg::ENG_IDLE;
        end
      endcase
    end
  end

endmodule // ee_access_engine

// [design/sticky_irq.sv]
// Sticky event status with write-one-to-clear, a mask and one level output.
// Assumes set and clear strobes are single-cycle and synchronous.
`timescale 1ns/1ps
module sticky_irq #(
  parameter int unsigned W = 2
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic [W-1:0] i_set,
  input wire logic i_clr_wr,
  input wire logic [W-1:0] i_clr_bits,
  input wire logic i_mask_wr,
  input wire logic [W-1:0] i_mask_bits,
  output logic [W-1:0] o_status,
  output logic [W-1:0] o_mask,
  output logic o_irq
);

  logic [W-1:0] nxt_status;
  logic [W-1:0] nxt_mask;

  // A set in the same cycle as its clear wins, so no event is lost.
  always_comb begin
    nxt_status = o_status;
    if (i_clr_wr) begin
      nxt_status = nxt_status & ~i_clr_bits;
    end
    nxt_status = nxt_status | i_set;
    nxt_mask = i_mask_wr ? i_mask_bits : o_mask;
  end

  // The output is registered so it never glitches on the bus side.
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_status <= '0;
      o_mask <= '0;
      o_irq <= 1'b0;
    end else begin
      o_status <= nxt_status;
      o_mask <= nxt_mask;
      o_irq <= |(nxt_status & nxt_mask);
    end
  end

endmodule // sticky_irq

// [test/cap_regs_checker_assertions.sv]
// Port-level assertions for the capability register block.
// Assumes one clock domain; the bind after the module attaches it.
`timescale 1ns/1ps
module cap_regs_checker (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input logic [31:0] o_prdata,
  input logic o_pready,
  input logic o_pslverr,
  input wire logic i_upstream_port,
  input wire logic i_msi_send,
  input logic o_msi_valid,
  input logic o_msi_addr_64,
  input logic o_ee_req,
  input pcie_cap_pkg::ee_cmd_t o_ee_cmd,
  input wire logic i_ee_done
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_arst_n);

  // A table access may only start on a taken write to the control dword.
  logic start_ok;
  assign start_ok = i_psel && i_penable && o_pready && i_pwrite &&
    i_upstream_port && i_pstrb[3] && !o_ee_req &&
    (i_paddr == pcie_cap_pkg::OFS_PD_CAP);

  a_apb_wait: assert property (
    i_psel && !i_penable |=> !o_pready ##1 o_pready)
    else $error("bus answer not after one wait state");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("bus answer longer than one cycle");
  a_err_zero: assert property (o_pslverr |-> o_pready && o_prdata == 0)
    else $error("error answer malformed");
  a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside answer cycle");
  a_addr64_cap: assert property ($past(i_arst_n) |-> o_msi_addr_64)
    else $error("wide address capability not advertised");
  a_table_start: assert property (
    start_ok |=> o_ee_req && o_ee_cmd.write == $past(i_pwdata[31]))
    else $error("table access did not start as written");
  a_table_addr: assert property (
    start_ok && i_pstrb[2] |=> o_ee_cmd.addr == $past(i_pwdata[23:18]))
    else $error("table access used wrong entry");
  a_req_cause: assert property ($rose(o_ee_req) |-> $past(start_ok))
    else $error("table access started without a command");
  a_cmd_hold: assert property (
    o_ee_req && !i_ee_done |=> o_ee_req && $stable(o_ee_cmd))
    else $error("table request changed before done");
  a_req_drop: assert property (o_ee_req && i_ee_done |=> !o_ee_req)
    else $error("table request held after done");
  a_msi_send: assert property (
    i_msi_send && !i_upstream_port |=> o_msi_valid)
    else $error("message not issued");
  a_msi_cause: assert property (
    o_msi_valid |-> $past(i_msi_send) && !$past(i_upstream_port))
    else $error("message issued without request");
endmodule // cap_regs_checker

bind pcie_msi_vpd_capability_regs cap_regs_checker cap_regs_checker_inst (
  .i_clock(i_clock), .i_arst_n(i_arst_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_upstream_port(i_upstream_port), .i_msi_send(i_msi_send),
  .o_msi_valid(o_msi_valid), .o_msi_addr_64(o_msi_addr_64),
  .o_ee_req(o_ee_req), .o_ee_cmd(o_ee_cmd), .i_ee_done(i_ee_done)
);

// [test/ee_table_model.sv]
// Behavioural EEPROM holding the product data table, one dword an entry.
// Assumes each request is held until its done pulse.
`timescale 1ns/1ps
module ee_table_model (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_req,
  input pcie_cap_pkg::ee_cmd_t i_cmd,
  input wire logic [7:0] i_delay,
  output logic o_done,
  output logic [31:0] o_rdata
);
  logic [31:0] mem [64];
  logic [7:0] wait_cnt;

  // Read data is only true in the done cycle; afterwards it shows the
  // inverse, so a late sample by the engine can never look correct.
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_done <= 1'b0;
      wait_cnt <= 8'h00;
      o_rdata <= 32'h0000_0000;
    end else if (o_done) begin
      o_done <= 1'b0;
      wait_cnt <= 8'h00;
      o_rdata <= ~o_rdata;
    end else if (i_req && wait_cnt >= i_delay) begin
      o_done <= 1'b1;
      if (i_cmd.write) begin
        mem[i_cmd.addr] <= i_cmd.data;
      end else begin
        o_rdata <= mem[i_cmd.addr];
      end
    end else if (i_req) begin
      wait_cnt <= wait_cnt + 8'h01;
    end
  end
endmodule // ee_table_model

// [test/tb.sv]
// Self-checking bench: register tests and table accesses over APB.
// Assumes the behavioural EEPROM model on the far side of the engine.
`timescale 1ns/1ps
module tb;
  logic i_clock, i_arst_n, i_psel, i_penable, i_pwrite, i_upstream_port;
  logic i_msi_send, o_pready, o_pslverr, o_msi_valid, o_msi_addr_64;
  logic o_ee_req, i_ee_done, o_irq, rerr;
  logic [7:0] i_paddr, ee_delay;
  logic [3:0] i_pstrb;
  logic [31:0] i_pwdata, o_prdata, o_msi_upper_address, i_ee_rdata, rdat;
  logic [15:0] o_msi_payload;
  logic [5:0] a6;
  pcie_cap_pkg::ee_cmd_t o_ee_cmd;
  int num_errors = 0;
  int check_count = 0;

  pcie_msi_vpd_capability_regs pcie_msi_vpd_capability_regs_inst (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_upstream_port(i_upstream_port), .i_msi_send(i_msi_send),
    .o_msi_valid(o_msi_valid), .o_msi_addr_64(o_msi_addr_64),
    .o_msi_upper_address(o_msi_upper_address),
    .o_msi_payload(o_msi_payload), .o_ee_req(o_ee_req),
    .o_ee_cmd(o_ee_cmd), .i_ee_done(i_ee_done), .i_ee_rdata(i_ee_rdata),
    .o_irq(o_irq)
  );
  ee_table_model ee_table_model_inst (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_req(o_ee_req),
    .i_cmd(o_ee_cmd), .i_delay(ee_delay), .o_done(i_ee_done),
    .o_rdata(i_ee_rdata)
  );

  // Free-running 100 MHz clock.
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    i_pstrb <= s;
    @(posedge i_clock);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    rdat = o_prdata;
    rerr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (o_pready !== 1'b1) begin
      num_errors++;
      $display("Error at %0t: no bus answer", $time);
      summarize();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    apb(1'b1, a, d, s);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    check(rdat, exp);
  endtask

  // Polls the operation flag for its completion value, within a bound.
  task automatic poll(input logic flag);
    int n;
    for (n = 0; n < 100; n++) begin
      apb(1'b0, pcie_cap_pkg::OFS_PD_CAP, 32'h0, 4'h0);
      if (rdat[31] === flag) break;
    end
    check({31'h0, rdat[31]}, {31'h0, flag});
    if (n == 100) summarize();
  endtask

  // Main sequence; the upstream role comes first.
  initial begin
    i_arst_n = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    i_pstrb = 4'h0;
    i_upstream_port = 1'b1;
    i_msi_send = 1'b0;
    ee_delay = 8'h01;
    repeat (3) @(posedge i_clock);
    i_arst_n <= 1'b1;
    rd(pcie_cap_pkg::OFS_PD_CAP, 32'h0000_a403);
    rd(pcie_cap_pkg::OFS_VND_CAP, 32'h000c_c409);
    rd(pcie_cap_pkg::OFS_TEST_FIRST, 32'h0400_1060);
    rd(pcie_cap_pkg::OFS_TEST_SECOND, 32'h0400_0800);
    wr(pcie_cap_pkg::OFS_VND_CAP, 32'hffff_ffff, 4'hf);
    wr(pcie_cap_pkg::OFS_PD_CAP, 32'h0000_ffff, 4'h3);
    wr(pcie_cap_pkg::OFS_TEST_FIRST, 32'hfbff_ef9f, 4'hf);
    wr(pcie_cap_pkg::OFS_TEST_SECOND, 32'h5a5a_a5a5, 4'hf);
    rd(pcie_cap_pkg::OFS_VND_CAP, 32'h000c_c409);
    rd(pcie_cap_pkg::OFS_PD_CAP, 32'h0000_a403);
    rd(pcie_cap_pkg::OFS_TEST_FIRST, 32'hfbff_ef9f);
    rd(pcie_cap_pkg::OFS_TEST_SECOND, 32'h5a5a_a5a5);
    rd(8'hf0, 32'h0);
    check({31'h0, rerr}, 32'h1);
    rd(pcie_cap_pkg::OFS_MSI_UPPER, 32'h0);
    check({31'h0, rerr}, 32'h1);
    $display("Register test done");
    // Only write completion may interrupt; read completion stays masked.
    wr(pcie_cap_pkg::OFS_IRQ_MASK, 32'h2, 4'h1);
    for (int i = 0; i < 2; i++) begin
      ee_delay <= (i == 1) ? 8'h14 : 8'h01;
      a6 = (i == 1) ? 6'h3f : 6'h00;
      wr(pcie_cap_pkg::OFS_PD_WORD, {26'h3037_ac0, a6}, 4'hf);
      wr(pcie_cap_pkg::OFS_PD_CAP, {1'b1, 7'h0, a6, 18'h0}, 4'hc);
      poll(1'b0);
      check({31'h0, o_irq}, 32'h1);
      wr(pcie_cap_pkg::OFS_IRQ_STATUS, 32'h2, 4'h1);
      rd(pcie_cap_pkg::OFS_IRQ_STATUS, 32'h0);
      check({31'h0, o_irq}, 32'h0);
      wr(pcie_cap_pkg::OFS_PD_WORD, 32'hdead_beef, 4'hf);
      wr(pcie_cap_pkg::OFS_PD_CAP, {1'b0, 7'h0, a6, 18'h0}, 4'hc);
      if (i == 1) begin
        // A second command while the slow read runs must be ignored.
        wr(pcie_cap_pkg::OFS_PD_CAP, 32'h8000_0000, 4'hc);
        rd(pcie_cap_pkg::OFS_PD_CAP, {1'b0, 7'h0, a6, 18'h0a403});
      end
      poll(1'b1);
      rd(pcie_cap_pkg::OFS_PD_CAP, {1'b1, 7'h0, a6, 18'h0a403});
      rd(pcie_cap_pkg::OFS_PD_WORD, {26'h3037_ac0, a6});
      rd(pcie_cap_pkg::OFS_IRQ_STATUS, 32'h1);
      check({31'h0, o_irq}, 32'h0);
      wr(pcie_cap_pkg::OFS_IRQ_STATUS, 32'h1, 4'h1);
    end
    // A read with no address lane reuses the stored entry address.
    wr(pcie_cap_pkg::OFS_PD_WORD, 32'hdead_beef, 4'hf);
    wr(pcie_cap_pkg::OFS_PD_CAP, 32'h0, 4'h8);
    poll(1'b1);
    rd(pcie_cap_pkg::OFS_PD_WORD, {26'h3037_ac0, 6'h3f});
    $display("Table test done");
    i_upstream_port <= 1'b0;
    rd(pcie_cap_pkg::OFS_MSI_UPPER, 32'h0);
    rd(pcie_cap_pkg::OFS_MSI_DATA, 32'h0);
    wr(pcie_cap_pkg::OFS_MSI_UPPER, 32'h1234_5678, 4'hf);
    wr(pcie_cap_pkg::OFS_MSI_DATA, 32'hffff_a5c3, 4'hf);
    rd(pcie_cap_pkg::OFS_MSI_UPPER, 32'h1234_5678);
    rd(pcie_cap_pkg::OFS_MSI_DATA, 32'h0000_a5c3);
    rd(pcie_cap_pkg::OFS_PD_CAP, 32'h0);
    check({31'h0, rerr}, 32'h1);
    @(posedge i_clock);
    i_msi_send <= 1'b1;
    @(posedge i_clock);
    i_msi_send <= 1'b0;
    @(posedge i_clock);
    check({31'h0, o_msi_valid}, 32'h1);
    check(o_msi_upper_address, 32'h1234_5678);
    check({16'h0, o_msi_payload}, 32'h0000_a5c3);
    check({31'h0, o_msi_addr_64}, 32'h1);
    $display("Message test done");
    summarize();
  end
endmodule // tb
